// *** logic/wcm_pkg.sv ***
// Package: register map, field layout and reset values of the wide counter measure unit
package wcm_pkg;
	// ----------------------------------------
	// Register indices and bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] IDX_CONTROL_ONE = 8'h14;
	localparam logic [ADDR_W-1:0] IDX_CONTROL_TWO = 8'h15;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h16;
	localparam logic [ADDR_W-1:0] IDX_COMPARE = 8'h17;
	localparam int IDX_SHIFT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Counter geometry
	// ----------------------------------------
	localparam int CNT_W = 18;
	localparam int SLOW_FC_LOW_BITS = 11;
	localparam logic [CNT_W-1:0] CNT_MAX = 18'h3ffff;
	localparam int DIVC_W = 23;
	localparam int DIVS_W = 15;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CONTROL_ONE_RESET = 8'h88;
	localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;

	// ----------------------------------------
	// Field codes
	// ----------------------------------------
	localparam logic [1:0] RUN_START = 2'h2;
	localparam logic [1:0] MODE_TIMER_EVENT = 2'h0;
	localparam logic [1:0] MODE_PULSE_WIDTH = 2'h2;
	localparam logic [1:0] MODE_FREQUENCY = 2'h3;
	localparam logic [2:0] SRC_FC = 3'h0;
	localparam logic [2:0] SRC_FS = 3'h1;
	localparam logic [2:0] SRC_DIV_A = 3'h2;
	localparam logic [2:0] SRC_DIV_B = 3'h3;
	localparam logic [2:0] SRC_DIV_C = 3'h4;
	localparam logic [2:0] SRC_DIV_D = 3'h5;
	localparam logic [2:0] SRC_DIV_E = 3'h6;
	localparam logic [2:0] SRC_EXTERNAL = 3'h7;
	localparam logic [1:0] GATE_EXTERNAL = 2'h0;
	localparam logic [1:0] GATE_NEIGHBOUR = 2'h2;
	localparam logic [1:0] GATE_INTERNAL = 2'h3;
	localparam logic [1:0] GCLK_A = 2'h0;
	localparam logic [1:0] GCLK_B = 2'h1;
	localparam logic [1:0] GCLK_C = 2'h2;

	// ----------------------------------------
	// Divider taps: bit n-1 of a free counter is a square wave of period 2^n
	// ----------------------------------------
	localparam int TAP_FC_23 = 22;
	localparam int TAP_FC_13 = 12;
	localparam int TAP_FC_11 = 10;
	localparam int TAP_FC_7 = 6;
	localparam int TAP_FC_3 = 2;
	localparam int TAP_FS_15 = 14;
	localparam int TAP_FS_5 = 4;
	localparam int TAP_FS_3 = 2;
	localparam int TAP_FC_12 = 11;
	localparam int TAP_FC_14 = 13;
	localparam int TAP_FS_4 = 3;
	localparam int TAP_FS_6 = 5;
endpackage

// *** logic/wcm_counter_unit.sv ***
// Module: 18-bit counter unit with compare, event and pulse-width modes, AXI4-Lite registers
//
// How it works
// [R1] Edge bit selects falling or both input edges
// [R2] Gate code 11 internal, 10 neighbour output; code 11 reads low, internal generator not built
// [R3] Gate irq edge bit: falling only or both
// [R4] Gate clock field picks a divider tap, low_div picks fc or fs
// [R5] Route bit clear drives neighbour output onto pin
// [R6] Software writes zero to control two bit0
// [R7] Software changes modes only while stopped
// [R8] Software keeps edge select falling for counting
// [R9] Status bit7 shows counting in gate high
// [R10] Status bit6 overflow, bits five..zero read zero
// [R11] Timer mode: match interrupts, clears, continues
// [R12] Internal clocks from fc/fs divider taps
// [R13] Slow fc source compares upper seven bits
// [R14] Timer mode provides slow-to-normal warm-up
// [R15] Event mode counts falling edges, match clears
// [R16] External input rate and width limited
// [R17] Pulse mode counts input AND internal clock
// [R18] Pulse mode interrupts on selected input edges
// [R19] Uncleared counter resumes from last value
// [R20] Wrap sets overflow until counter cleared
// [R21] Software reads count while stopped, clears
// [R22] Stopping with input high raises interrupt
// [R23] Gate code 00 selects external input
// [R24] Clear bit zero clears counter, returns one
// [R25] Compare read returns live counter value
// [R26] Low byte write holds compare until high
// [R27] External input synchronised before edge detection
`timescale 1ns/10ps
module wcm_counter_unit
	import wcm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_count_input,
	input wire logic fs_tick,
	input wire logic low_divider_flag,
	input wire logic slow_mode,
	input wire logic neighbour_timer_output,
	output logic shared_port_pin_out,
	output logic shared_port_pin_oe,
	output logic counter_interrupt,
	output logic gate_clock_tick
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] ctrl1_q, ctrl1_d;
	logic [7:0] ctrl2_q, ctrl2_d;
	logic [CNT_W-1:0] cmp_q, cmp_d;
	logic armed_q, armed_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic ovf_q, ovf_d;
	logic [DIVC_W-1:0] divc_q, divc_d;
	logic [DIVS_W-1:0] divs_q, divs_d;
	logic sync1_q, sync2_q, sync3_q;
	logic ext_q, ext_d;
	logic src_lvl_q, src_lvl_d;
	logic and_q, and_d;
	logic pw_gate_q, pw_gate_d;
	logic gclk_lvl_q, gclk_lvl_d;
	logic irq_q, irq_d;
	logic gtick_q, gtick_d;
	logic pin_q, pin_d, pin_oe_q, pin_oe_d;
	logic awready_q, awready_d, bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	// Field views
	logic edge_both, gate_irq_both, route_off, running, low_div;
	logic [1:0] gate_src, gate_clk, mode;
	logic [2:0] src;
	logic [ADDR_W-1:0] widx, ridx;
	logic wr_take, rd_take;
	assign edge_both = ctrl2_q[7];
	assign gate_src = ctrl2_q[6:5];
	assign gate_irq_both = ctrl2_q[4];
	assign gate_clk = ctrl2_q[3:2];
	assign route_off = ctrl2_q[1];
	assign running = (ctrl1_q[6:5] == RUN_START);
	assign src = ctrl1_q[4:2];
	assign mode = ctrl1_q[1:0];
	assign low_div = low_divider_flag | slow_mode;
	assign widx = s_axi_awaddr >> IDX_SHIFT;
	assign ridx = s_axi_araddr >> IDX_SHIFT;
	assign wr_take = awready_q & s_axi_awvalid & s_axi_wvalid;
	assign rd_take = arready_q & s_axi_arvalid;

	function automatic logic mapped(input logic [ADDR_W-1:0] idx);
		mapped = (idx == IDX_CONTROL_ONE) || (idx == IDX_CONTROL_TWO) ||
			(idx == IDX_STATUS) || (idx == IDX_COMPARE);
	endfunction

	// ----------------------------------------
	// External input synchroniser
	// ----------------------------------------
	// A level is accepted only once the second and third stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else if (ce) begin
			sync1_q <= external_count_input; // [R27]
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ----------------------------------------
	// Prescalers, edges and counter
	// ----------------------------------------
	logic src_always, src_step, ext_fall, ext_rise, gate_lvl, cnt_tick, match, gate_irq;
	logic pw_in, gtap;
	always_comb begin
		divc_d = divc_q + 1'b1;
		divs_d = fs_tick ? divs_q + 1'b1 : divs_q;
		ext_d = (sync2_q == sync3_q) ? sync3_q : ext_q; // [R27]
		ext_fall = ext_q & ~ext_d;
		ext_rise = ~ext_q & ext_d;
		// Internal source level; fc and fs are steps rather than waves
		src_always = 1'b0;
		src_step = 1'b0;
		src_lvl_d = 1'b0;
		unique case (src) // [R12]
			SRC_FC: begin
				src_always = 1'b1;
				src_step = 1'b1;
			end
			SRC_FS: begin
				src_always = 1'b1;
				src_step = fs_tick;
			end
			SRC_DIV_A: src_lvl_d = low_div ? divs_d[TAP_FS_15] : divc_d[TAP_FC_23];
			SRC_DIV_B: src_lvl_d = low_div ? divs_d[TAP_FS_5] : divc_d[TAP_FC_13];
			SRC_DIV_C: src_lvl_d = low_div ? divs_d[TAP_FS_3] : divc_d[TAP_FC_11];
			SRC_DIV_D: src_lvl_d = divc_d[TAP_FC_7];
			SRC_DIV_E: src_lvl_d = divc_d[TAP_FC_3];
			SRC_EXTERNAL: src_lvl_d = 1'b0;
		endcase
		if (!src_always) begin
			src_step = src_lvl_q & ~src_lvl_d;
		end
		// Gate clock tap for the window gate generator
		unique case (gate_clk) // [R4]
			GCLK_A: gtap = low_div ? divs_d[TAP_FS_4] : divc_d[TAP_FC_12];
			GCLK_B: gtap = low_div ? divs_d[TAP_FS_5] : divc_d[TAP_FC_13];
			GCLK_C: gtap = low_div ? divs_d[TAP_FS_6] : divc_d[TAP_FC_14];
			default: gtap = 1'b0;
		endcase
		gclk_lvl_d = gtap;
		gtick_d = gclk_lvl_q & ~gtap;
		// Window gate source; the internal generator is not built and reads low
		unique case (gate_src)
			GATE_EXTERNAL: gate_lvl = ext_q; // [R23]
			GATE_NEIGHBOUR: gate_lvl = neighbour_timer_output; // [R2]
			GATE_INTERNAL: gate_lvl = 1'b0; // [R2]
			default: gate_lvl = 1'b0;
		endcase
		// Pulse width: falling edge of input AND internal clock
		pw_in = running & ext_d;
		and_d = src_lvl_d & pw_in;
		pw_gate_d = pw_in;
		cnt_tick = 1'b0;
		gate_irq = 1'b0;
		if (running) begin
			unique case (mode)
				MODE_TIMER_EVENT: begin
					if (src == SRC_EXTERNAL) begin
						cnt_tick = edge_both ? (ext_fall | ext_rise) : ext_fall; // [R1] [R15]
					end else begin
						cnt_tick = src_step; // [R11]
					end
				end
				MODE_PULSE_WIDTH: begin
					cnt_tick = src_always ? (src_step & ext_d) : (and_q & ~and_d); // [R17]
				end
				default: cnt_tick = 1'b0;
			endcase
		end
		// Stopping while the input is high drops the gate, so it interrupts too
		if (mode == MODE_PULSE_WIDTH) begin
			gate_irq = (pw_gate_q & ~pw_in) | (gate_irq_both & ~pw_gate_q & pw_in); // [R18] [R3] [R22]
		end
		// Slow mode with fc ignores the low compare bits
		if (slow_mode && src == SRC_FC) begin
			match = cnt_q[CNT_W-1:SLOW_FC_LOW_BITS] == cmp_q[CNT_W-1:SLOW_FC_LOW_BITS]; // [R13]
		end else begin
			match = cnt_q == cmp_q;
		end
		match = match & armed_q & running & (mode == MODE_TIMER_EVENT); // [R26]
		cnt_d = cnt_q;
		ovf_d = ovf_q;
		if (match) begin
			cnt_d = '0; // [R11] [R14] [R15]
		end else if (cnt_tick) begin
			cnt_d = cnt_q + 1'b1; // [R19]
			if (cnt_q == CNT_MAX) begin
				ovf_d = 1'b1; // [R20]
			end
		end
		irq_d = match | gate_irq; // [R11]
		pin_d = neighbour_timer_output;
		pin_oe_d = ~route_off; // [R5]
		// Register writes
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		cmp_d = cmp_q;
		armed_d = armed_q;
		ctrl1_d[7] = 1'b1; // [R24]
		if (wr_take && s_axi_wstrb[0]) begin
			unique case (widx)
				IDX_CONTROL_ONE: begin
					ctrl1_d[6:0] = s_axi_wdata[6:0];
					if (!s_axi_wdata[7]) begin
						cnt_d = '0; // [R24]
						ovf_d = 1'b0; // [R24]
					end
				end
				IDX_CONTROL_TWO: ctrl2_d = {s_axi_wdata[7:1], 1'b0}; // [R6]
				default: ctrl2_d = ctrl2_q;
			endcase
		end
		if (wr_take && widx == IDX_COMPARE) begin
			if (s_axi_wstrb[0]) begin
				cmp_d[7:0] = s_axi_wdata[7:0];
				armed_d = 1'b0; // [R26]
			end
			if (s_axi_wstrb[1]) begin
				cmp_d[15:8] = s_axi_wdata[15:8];
				armed_d = 1'b0; // [R26]
			end
			if (s_axi_wstrb[2]) begin
				cmp_d[CNT_W-1:16] = s_axi_wdata[CNT_W-1:16];
				armed_d = 1'b1; // [R26]
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// One write and one read in flight; address and data are taken together
	logic [7:0] status_v;
	always_comb begin
		status_v = 8'h00; // [R10]
		if (mode == MODE_PULSE_WIDTH) begin
			status_v[7] = running & ext_q; // [R9]
		end else if (mode == MODE_FREQUENCY) begin
			status_v[7] = running & gate_lvl; // [R9]
		end else begin
			status_v[7] = running; // [R9]
		end
		status_v[6] = ovf_q; // [R10] [R20]
		awready_d = ~awready_q & ~bvalid_q & s_axi_awvalid & s_axi_wvalid;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_take) begin
			bvalid_d = 1'b1;
			bresp_d = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
		end
		arready_d = ~arready_q & ~rvalid_q & s_axi_arvalid;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (rd_take) begin
			rvalid_d = 1'b1;
			rresp_d = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
			unique case (ridx)
				IDX_CONTROL_ONE: rdata_d = {24'h000000, ctrl1_q};
				IDX_CONTROL_TWO: rdata_d = {24'h000000, ctrl2_q};
				IDX_STATUS: rdata_d = {24'h000000, status_v};
				IDX_COMPARE: rdata_d = {14'h0000, cnt_q}; // [R25]
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_q <= CONTROL_ONE_RESET;
			ctrl2_q <= CONTROL_TWO_RESET;
			cmp_q <= '0;
			armed_q <= 1'b1;
			cnt_q <= '0;
			ovf_q <= 1'b0;
			divc_q <= '0;
			divs_q <= '0;
			ext_q <= 1'b0;
			src_lvl_q <= 1'b0;
			and_q <= 1'b0;
			pw_gate_q <= 1'b0;
			gclk_lvl_q <= 1'b0;
			irq_q <= 1'b0;
			gtick_q <= 1'b0;
			pin_q <= 1'b0;
			pin_oe_q <= 1'b0;
			awready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end else if (ce) begin
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			cmp_q <= cmp_d;
			armed_q <= armed_d;
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
			divc_q <= divc_d;
			divs_q <= divs_d;
			ext_q <= ext_d;
			src_lvl_q <= src_lvl_d;
			and_q <= and_d;
			pw_gate_q <= pw_gate_d;
			gclk_lvl_q <= gclk_lvl_d;
			irq_q <= irq_d;
			gtick_q <= gtick_d;
			pin_q <= pin_d;
			pin_oe_q <= pin_oe_d;
			awready_q <= awready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = awready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign counter_interrupt = irq_q;
	assign gate_clock_tick = gtick_q;
	assign shared_port_pin_out = pin_q;
	assign shared_port_pin_oe = pin_oe_q;
endmodule // wcm_counter_unit

// *** bench/wcm_pulse_source.sv ***
// Partner model: external pulse source on the count input
`timescale 1ns/10ps
module wcm_pulse_source (
	input wire logic aclk,
	output logic ext_level
);
	initial ext_level = 1'b0;
	// A width of 8 per level keeps the rate at fc/16, the fastest allowed
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			ext_level <= 1'b1;
			repeat (w) @(posedge aclk);
			ext_level <= 1'b0;
			repeat (w) @(posedge aclk);
		end
	endtask
	task automatic put(input logic v);
		ext_level <= v;
		@(posedge aclk);
	endtask
endmodule // wcm_pulse_source

// *** bench/wcm_counter_unit_properties.sv ***
// Checker: port-level properties of the wide counter unit
`timescale 1ns/10ps
module wcm_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic neighbour_timer_output,
	input wire logic shared_port_pin_out,
	input wire logic counter_interrupt
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_pin_follow: assert property ($past(aresetn, 2) |->
		shared_port_pin_out == $past(neighbour_timer_output)) else $error("pin copy wrong");
	a_irq_single: assert property (counter_interrupt |=> !counter_interrupt)
		else $error("interrupt longer than one cycle");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:18] == 14'h0)
		else $error("read data upper bits set");
	a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("awready and wready differ");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held");
	a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("no write response");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule // wcm_checker

bind wcm_counter_unit wcm_checker i_wcm_checker (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .neighbour_timer_output,
	.shared_port_pin_out, .counter_interrupt);

// *** bench/testbench.sv ***
// Testbench: register, counter and pin checks of the wide counter unit
`timescale 1ns/10ps
module testbench;
	import wcm_pkg::*;
	localparam logic [7:0] A_C1 = IDX_CONTROL_ONE << IDX_SHIFT;
	localparam logic [7:0] A_C2 = IDX_CONTROL_TWO << IDX_SHIFT;
	localparam logic [7:0] A_ST = IDX_STATUS << IDX_SHIFT;
	localparam logic [7:0] A_CMP = IDX_COMPARE << IDX_SHIFT;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, external_count_input, neighbour_timer_output, fs_tick;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic shared_port_pin_out, shared_port_pin_oe, counter_interrupt, gate_clock_tick;
	logic low_divider_flag, slow_mode;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int irqs = 0;
	int n, base;

	wcm_counter_unit i_wcm_counter_unit (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .external_count_input, .fs_tick, .low_divider_flag,
		.slow_mode, .neighbour_timer_output, .shared_port_pin_out, .shared_port_pin_oe,
		.counter_interrupt, .gate_clock_tick);
	wcm_pulse_source i_wcm_pulse_source (.aclk, .ext_level(external_count_input));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Cycle count doubles as watchdog and low-frequency tick source
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		fs_tick <= (cyc[2:0] == 3'h7);
		if (counter_interrupt === 1'b1)
			irqs <= irqs + 1;
		// The gate period loop dominates, ending near cycle 49000; the rest adds about five thousand cycles
		if (cyc == 80000) begin
			num_errors++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rdat, exp);
	endtask
	// Cycles between two pulses of the gate tick (g=1) or the interrupt (g=0)
	task automatic period(input bit g, output int p);
		do @(posedge aclk); while ((g ? gate_clock_tick : counter_interrupt) !== 1'b1);
		p = 0;
		do begin
			@(posedge aclk);
			p++;
		end while ((g ? gate_clock_tick : counter_interrupt) !== 1'b1);
	endtask
	task automatic finish_test();
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, neighbour_timer_output, low_divider_flag, slow_mode} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awprot, s_axi_arprot} = '0;
		ce = 1'b1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(A_C1, 32'h88);
		rc(A_C2, 32'h00);
		rc(A_ST, 32'h00);
		rc(A_CMP, 32'h0);
		rc(8'h60, 32'h0);
		chk(resp, RESP_SLVERR);
		wr(8'h60, 32'h1, 4'hf);
		chk(resp, RESP_SLVERR);
		for (int k = 0; k < 2; k++) begin
			wr(A_C2, 32'(k << 2), 4'h1);
			period(1'b1, n);
			period(1'b1, n);
			chk(n, 4096 << k);
		end
		wr(A_C2, 32'hda, 4'h1);
		rc(A_C2, 32'hda);
		chk(shared_port_pin_oe, 1'b0);
		wr(A_C2, 32'h00, 4'h1);
		neighbour_timer_output <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({shared_port_pin_oe, shared_port_pin_out}, 2'b11);
		wr(A_ST, 32'hff, 4'hf);
		rc(A_ST, 32'h0);
		wr(A_CMP, 32'd10, 4'h7);
		wr(A_C1, 32'h80, 4'h1);
		wr(A_C1, 32'hc0, 4'h1);
		rc(A_ST, 32'h80);
		period(1'b0, n);
		chk(n, 11);
		wr(A_CMP, 32'h30, 4'h1);
		base = irqs;
		repeat (40) @(posedge aclk);
		chk(irqs - base, 0);
		wr(A_C1, 32'h40, 4'h1);
		rc(A_C1, 32'hc0);
		wr(A_CMP, 32'h0, 4'h4);
		period(1'b0, n);
		chk(n, 49);
		wr(A_C1, 32'h00, 4'h1);
		rc(A_CMP, 32'h0);
		rc(A_ST, 32'h0);
		wr(A_CMP, 32'd3, 4'h7);
		wr(A_C1, 32'h9c, 4'h1);
		wr(A_C1, 32'hdc, 4'h1);
		base = irqs;
		i_wcm_pulse_source.pulses(3, 8);
		chk(irqs - base, 1);
		rc(A_CMP, 32'h0);
		i_wcm_pulse_source.pulses(2, 8);
		rc(A_CMP, 32'h2);
		wr(A_C1, 32'h1c, 4'h1);
		wr(A_CMP, 32'h3ffff, 4'h7);
		for (int k = 0; k < 2; k++) begin
			wr(A_C2, 32'(k << 4), 4'h1);
			wr(A_C1, 32'h82, 4'h1);
			wr(A_C1, 32'hc2, 4'h1);
			base = irqs;
			i_wcm_pulse_source.pulses(1, 20);
			chk(irqs - base, k + 1);
			rd(A_CMP);
			chk(rdat >= 19 && rdat <= 21, 1'b1);
			wr(A_C1, 32'h02, 4'h1);
		end
		wr(A_C1, 32'hc2, 4'h1);
		i_wcm_pulse_source.put(1'b1);
		repeat (8) @(posedge aclk);
		base = irqs;
		wr(A_C1, 32'h82, 4'h1);
		repeat (4) @(posedge aclk);
		chk(irqs - base, 1);
		i_wcm_pulse_source.put(1'b0);
		// Divided and low-frequency sources: a match clears between ticks, so cmp ticks a period
		wr(A_CMP, 32'h2, 4'h7);
		wr(A_C1, 32'h18, 4'h1);
		wr(A_C1, 32'hd8, 4'h1);
		period(1'b0, n);
		chk(n, 32'h10);
		wr(A_C1, 32'h04, 4'h1);
		wr(A_C1, 32'hc4, 4'h1);
		period(1'b0, n);
		chk(n, 32'h10);
		wr(A_C1, 32'h10, 4'h1);
		low_divider_flag <= 1'b1;
		wr(A_C1, 32'hd0, 4'h1);
		period(1'b0, n);
		chk(n, 32'h80);
		period(1'b1, n);
		chk(n, 32'h80);
		// Slow mode with fc: only the upper compare bits take part
		wr(A_C1, 32'h00, 4'h1);
		low_divider_flag <= 1'b0;
		slow_mode <= 1'b1;
		wr(A_CMP, 32'h805, 4'h7);
		wr(A_C1, 32'hc0, 4'h1);
		period(1'b0, n);
		chk(n, 32'h801);
		finish_test();
	end
endmodule // testbench
